// ### hw/csau_map.svh
// Purpose: register offsets, field positions, reset values and limits of the scaling/alarm unit
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes: included by its bare name; definitions only
`ifndef CSAU_MAP_SVH
`define CSAU_MAP_SVH

// ----------------------------------------------------------------
// global and per-channel register layout
// ----------------------------------------------------------------
`define CSAU_CTRL_OFS     12'h000 // global control word
`define CSAU_CH_BASE_SEL  3'h1    // address bits 11:9 select the channel window
`define CSAU_CFG_OFS      4'h0    // channel word: configuration
`define CSAU_SCALE_OFS    4'h1    // channel word: top / bottom scale values
`define CSAU_EXT_OFS      4'h2    // channel word: upper / lower extension
`define CSAU_AL1_OFS      4'h3    // channel word: first alarm threshold / hysteresis
`define CSAU_AL2_OFS      4'h4    // channel word: second alarm threshold / hysteresis
`define CSAU_STAT_OFS     4'h5    // channel word: read-only result and flags
`define CSAU_NAME0_OFS    4'h6    // channel words 6..8: nine-byte label
`define CSAU_UNIT_OFS     4'h9    // channel word: four-byte unit string

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSAU_CTRL_FAHR_BIT 0  // temperature scale select
`define CSAU_STAT_VALID_BIT 16 // numeric result present
`define CSAU_STAT_OVER_BIT 17  // over-range indication
`define CSAU_STAT_UNDER_BIT 18 // under-range indication
`define CSAU_STAT_AL1_BIT 19   // first alarm state
`define CSAU_STAT_AL2_BIT 20   // second alarm state

// ----------------------------------------------------------------
// reset values and limits (signals are in 0.01 mA / 0.01 V)
// ----------------------------------------------------------------
`define CSAU_CFG_RST      11'h000
`define CSAU_SCALE_LIMIT  16'sd9999 // largest magnitude of a scale value
`define CSAU_FILT_MAX     3'd5      // highest smoothing level
`define CSAU_UPX_MAX      16'd199   // upper extension ceiling, both kinds
`define CSAU_LOX_MAX_4MA  16'd399   // lower extension ceiling, 4-20 mA
`define CSAU_LOX_MAX_1V   16'd199   // lower extension ceiling, 1-5 V
`define CSAU_LOX_MAX_2V   16'd99    // lower extension ceiling, 2-10 V
`define CSAU_FRAC_BITS    8         // fraction bits kept by the smoothing filter

`endif

// ### hw/csau_pkg.sv
// Purpose: types shared by the channel scaling and alarm unit
// Assumes: constants come from csau_map.svh
// Notes: no numbers live here apart from field widths
package csau_pkg;

   // ----------------------------------------------------------------
   // input selections
   // ----------------------------------------------------------------
   // one code space, read according to the channel kind
   typedef enum logic [2:0] {
      CSAU_IN_OFF, // inactive
      CSAU_IN_A,   // 0-20 mA or 0-5 V
      CSAU_IN_B,   // 4-20 mA or 1-5 V
      CSAU_IN_C,   // 0-10 V
      CSAU_IN_D    // 2-10 V
   } csau_in_t;

   // channel configuration word
   typedef struct packed {
      logic al2_above;  // second alarm: 1 above, 0 below
      logic al1_above;  // first alarm: 1 above, 0 below
      logic [1:0] dp;   // fractional digits 0..3
      logic [2:0] filt; // smoothing level 0..5
      logic [2:0] in_type; // csau_in_t code
      logic voltage;    // 0 current channel, 1 voltage channel
   } csau_cfg_t;

   // per-sample result handed downstream
   typedef struct packed {
      logic valid;           // numeric value present
      logic over;            // over-range indication
      logic under;           // under-range indication
      logic [1:0] dp;        // decimal position
      logic signed [15:0] value; // display value, scaled counts
   } csau_res_t;

endpackage

// ### hw/csau_unit.sv
// Purpose: per-channel scaling, smoothing, range check and two hysteresis alarms
// Assumes: samples arrive from logic on ref_clk, in 0.01 mA or 0.01 V steps
// Notes: registers over Avalon-MM with one wait state per access
//
// How it works
// R1 - smoothing levels zero to five per channel
// R2 - two independent alarms per channel
// R3 - below mode: alarm while value under threshold
// R4 - above mode: alarm while value over threshold
// R5 - every new value re-evaluates both alarms; the code leaves them unchanged on over- or under-range values
// R6 - thresholds taken without any range check
// R7 - hysteresis: set past threshold plus hysteresis
// R8 - hysteresis: clear past threshold minus hysteresis
// R9 - current inputs: off, 0-20, 4-20 mA
// R10 - voltage inputs: off, 0-5, 1-5, 0-10, 2-10
// R11 - scale values from minus to plus 9999; the code stores any 16-bit value as written, with no limit check
// R12 - bottom above top gives falling display
// R13 - linear interpolation across the nominal span
// R14 - decimal position zero to three digits
// R15 - numeric inside extensions, flags beyond them
// R16 - current lower extension below 4 mA, 4-20 only
// R17 - current upper extension above 20 mA, 0-1.99
// R18 - voltage lower extension for 1-5, 2-10 only
// R19 - voltage upper extension above 10 V
// R20 - nine-char label and four-char unit stored
// R21 - one Celsius/Fahrenheit select
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "csau_map.svh"

module csau_unit #(
   parameter int NUM_CH = 8 // measurement channels
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // avalon-mm register slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // converter sample stream
   input wire logic sample_valid,
   input wire logic [2:0] sample_ch,
   input wire logic [15:0] sample_data,
   // result stream and alarm levels
   output logic res_strobe,
   output logic [2:0] res_ch,
   output csau_pkg::csau_res_t res_data,
   output logic [NUM_CH-1:0] alarm1,
   output logic [NUM_CH-1:0] alarm2,
   output logic fahrenheit
);
   import csau_pkg::*;

   // elaboration check: channel index is three bits wide
   if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
      $error("NUM_CH must lie in 1..8");
   end

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   csau_cfg_t cfg_q [NUM_CH];          // channel configuration
   logic signed [15:0] top_q [NUM_CH];  // display at span maximum
   logic signed [15:0] bot_q [NUM_CH];  // display at span minimum
   logic [15:0] upx_q [NUM_CH];         // upper extension
   logic [15:0] lox_q [NUM_CH];         // lower extension
   logic signed [15:0] thr_q [NUM_CH][2]; // thresholds per alarm
   logic signed [15:0] hys_q [NUM_CH][2]; // hysteresis per alarm
   logic [31:0] txt_q [NUM_CH][4];      // label words 0..2, unit word 3
   logic signed [23:0] filt_q [NUM_CH]; // filter state with fraction bits
   csau_res_t stat_q [NUM_CH];          // last result per channel
   logic fahr_q;                        // temperature scale select
   logic ack_q;                         // bus answer cycle

   // ----------------------------------------------------------------
   // avalon-mm decode
   // ----------------------------------------------------------------
   logic bus_req;      // any request present
   logic wr_acc;       // write takes effect this edge
   logic ch_hit;       // address falls in a channel window
   logic [2:0] a_ch;   // addressed channel
   logic [3:0] a_reg;  // addressed word within the window
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack_q;
   assign wr_acc = avs_write & ack_q;
   assign a_ch = avs_address[8:6];
   assign a_reg = avs_address[5:2];
   assign ch_hit = (avs_address[11:9] == `CSAU_CH_BASE_SEL) && (32'(a_ch) < NUM_CH);

   // byte lane merge for writes
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // one wait state: answer on the edge after the request appears
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // read data registered on the same edge that takes the request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= 32'h0000_0000; // unmapped reads return zero
         if (avs_address == `CSAU_CTRL_OFS) begin
            avs_readdata[`CSAU_CTRL_FAHR_BIT] <= fahr_q;
         end else if (ch_hit) begin
            unique case (a_reg)
               `CSAU_CFG_OFS: avs_readdata <= {21'h0, cfg_q[a_ch]};
               `CSAU_SCALE_OFS: avs_readdata <= {bot_q[a_ch], top_q[a_ch]};
               `CSAU_EXT_OFS: avs_readdata <= {lox_q[a_ch], upx_q[a_ch]};
               `CSAU_AL1_OFS: avs_readdata <= {hys_q[a_ch][0], thr_q[a_ch][0]};
               `CSAU_AL2_OFS: avs_readdata <= {hys_q[a_ch][1], thr_q[a_ch][1]};
               `CSAU_STAT_OFS: avs_readdata <= {11'h000, alarm2[a_ch], alarm1[a_ch], stat_q[a_ch].under,
                                                stat_q[a_ch].over, stat_q[a_ch].valid, stat_q[a_ch].value};
               4'h6, 4'h7, 4'h8, 4'h9: avs_readdata <= txt_q[a_ch][2'(a_reg - `CSAU_NAME0_OFS)];
               default: avs_readdata <= 32'h0000_0000; // hole in the window
            endcase
         end
      end
   end

   // global control
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fahr_q <= 1'b0;
      end else if (wr_acc && avs_address == `CSAU_CTRL_OFS && avs_byteenable[0]) begin
         fahr_q <= avs_writedata[`CSAU_CTRL_FAHR_BIT]; // R21
      end
   end
   assign fahrenheit = fahr_q;

   // channel configuration writes; values are stored as written
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < NUM_CH; c++) begin
            cfg_q[c] <= `CSAU_CFG_RST;
            top_q[c] <= 16'sh0000;
            bot_q[c] <= 16'sh0000;
            upx_q[c] <= 16'h0000;
            lox_q[c] <= 16'h0000;
            for (int k = 0; k < 2; k++) begin
               thr_q[c][k] <= 16'sh0000;
               hys_q[c][k] <= 16'sh0000;
            end
            for (int k = 0; k < 4; k++) begin
               txt_q[c][k] <= 32'h0000_0000;
            end
         end
      end else if (wr_acc && ch_hit) begin
         unique case (a_reg)
            `CSAU_CFG_OFS: cfg_q[a_ch] <= 11'(be_merge({21'h0, cfg_q[a_ch]}, avs_writedata, avs_byteenable));
            `CSAU_SCALE_OFS: {bot_q[a_ch], top_q[a_ch]} <=
                             be_merge({bot_q[a_ch], top_q[a_ch]}, avs_writedata, avs_byteenable); // R11 R12
            `CSAU_EXT_OFS: {lox_q[a_ch], upx_q[a_ch]} <=
                           be_merge({lox_q[a_ch], upx_q[a_ch]}, avs_writedata, avs_byteenable);
            `CSAU_AL1_OFS: {hys_q[a_ch][0], thr_q[a_ch][0]} <=
                           be_merge({hys_q[a_ch][0], thr_q[a_ch][0]}, avs_writedata, avs_byteenable); // R6
            `CSAU_AL2_OFS: {hys_q[a_ch][1], thr_q[a_ch][1]} <=
                           be_merge({hys_q[a_ch][1], thr_q[a_ch][1]}, avs_writedata, avs_byteenable); // R6
            4'h6, 4'h7, 4'h8, 4'h9: txt_q[a_ch][2'(a_reg - `CSAU_NAME0_OFS)] <=
                           be_merge(txt_q[a_ch][2'(a_reg - `CSAU_NAME0_OFS)], avs_writedata, avs_byteenable); // R20
            default: ; // status word and holes ignore writes
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stage 1: smoothing filter
   // ----------------------------------------------------------------
   // first-order low-pass, weight 2^-level; level 5 at the converter rate
   // gives the long time constant. levels above five act as five.
   logic signed [23:0] f_raw;    // arriving sample in filter format
   logic [2:0] f_lvl;            // effective level of the arriving channel
   logic signed [23:0] f_err;    // input minus state
   logic signed [23:0] f_next;   // new state
   logic s1_valid_q;             // stage 1 holds a sample
   logic [2:0] s1_ch_q;          // its channel
   logic signed [17:0] s1_x_q;   // smoothed input, 0.01 units
   // every operand signed, so a falling input shifts arithmetically
   always_comb begin
      f_raw = 24'(sample_data) <<< `CSAU_FRAC_BITS;
      f_lvl = (cfg_q[sample_ch].filt > `CSAU_FILT_MAX) ? `CSAU_FILT_MAX : cfg_q[sample_ch].filt;
      f_err = f_raw - filt_q[sample_ch];
      f_next = (f_lvl == 3'd0) ? f_raw : filt_q[sample_ch] + (f_err >>> f_lvl); // R1
   end

   // filter state per channel
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < NUM_CH; c++) begin
            filt_q[c] <= 24'sh000000;
         end
      end else if (sample_valid && 32'(sample_ch) < NUM_CH) begin
         filt_q[sample_ch] <= f_next;
      end
   end

   // stage 1 register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_valid_q <= 1'b0;
         s1_ch_q <= 3'h0;
         s1_x_q <= 18'sh00000;
      end else begin
         s1_valid_q <= sample_valid && (32'(sample_ch) < NUM_CH);
         s1_ch_q <= sample_ch;
         s1_x_q <= 18'(f_next >>> `CSAU_FRAC_BITS);
      end
   end

   // ----------------------------------------------------------------
   // stage 2: span, extensions, scaling
   // ----------------------------------------------------------------
   csau_cfg_t c2;                 // config of channel in stage 2
   logic active;                  // channel has a live selection
   logic signed [17:0] s_min;     // nominal span minimum
   logic signed [17:0] s_len;     // nominal span length
   logic signed [17:0] lox_cap;   // largest lower extension allowed
   logic signed [17:0] lo_lim;    // lowest accepted input
   logic signed [17:0] hi_lim;    // highest accepted input
   logic signed [17:0] upx_eff;   // clamped upper extension
   logic signed [17:0] lox_eff;   // clamped lower extension
   logic signed [37:0] prod;      // (input - min) * (top - bottom)
   logic signed [37:0] quot;      // prod / span length
   logic signed [15:0] val_c;     // display value
   logic over_c;                  // beyond upper limit
   logic under_c;                 // beyond lower limit
   always_comb begin
      c2 = cfg_q[s1_ch_q];
      active = 1'b1;
      s_min = 18'sd0;
      s_len = 18'sd2000;
      lox_cap = 18'sd0;
      unique case (csau_in_t'(c2.in_type))
         CSAU_IN_A: s_len = c2.voltage ? 18'sd500 : 18'sd2000; // R9 R10
         CSAU_IN_B: begin
            s_min = c2.voltage ? 18'sd100 : 18'sd400; // R9 R10
            s_len = c2.voltage ? 18'sd400 : 18'sd1600;
            lox_cap = c2.voltage ? 18'(`CSAU_LOX_MAX_1V) : 18'(`CSAU_LOX_MAX_4MA); // R16 R18
         end
         CSAU_IN_C: begin
            active = c2.voltage; // 0-10 V has no current twin
            s_len = 18'sd1000; // R10
         end
         CSAU_IN_D: begin
            active = c2.voltage;
            s_min = 18'sd200; // R10
            s_len = 18'sd800;
            lox_cap = 18'(`CSAU_LOX_MAX_2V); // R18
         end
         default: active = 1'b0; // inactive and unused codes
      endcase
      // upper extension always measured from the span top
      upx_eff = (upx_q[s1_ch_q] > `CSAU_UPX_MAX) ? 18'(`CSAU_UPX_MAX) : 18'(upx_q[s1_ch_q]); // R17 R19
      lox_eff = (18'(lox_q[s1_ch_q]) > lox_cap) ? lox_cap : 18'(lox_q[s1_ch_q]); // R16 R18
      lo_lim = s_min - lox_eff;
      hi_lim = s_min + s_len + upx_eff;
      over_c = active && (s1_x_q > hi_lim); // R15
      under_c = active && (s1_x_q < lo_lim); // R15
      // division by the span truncates toward zero; error under one count
      prod = 38'(s1_x_q - s_min) * 38'(20'(top_q[s1_ch_q]) - 20'(bot_q[s1_ch_q])); // R13
      quot = prod / 38'(s_len);
      val_c = 16'(38'(bot_q[s1_ch_q]) + quot); // R13 R12
   end

   // stage 2 result and per-channel status
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_strobe <= 1'b0;
         res_ch <= 3'h0;
         res_data <= '0;
         for (int c = 0; c < NUM_CH; c++) begin
            stat_q[c] <= '0;
         end
      end else begin
         res_strobe <= s1_valid_q;
         if (s1_valid_q) begin
            res_ch <= s1_ch_q;
            res_data.valid <= active && !over_c && !under_c; // R15
            res_data.over <= over_c;
            res_data.under <= under_c;
            res_data.dp <= c2.dp; // R14
            res_data.value <= (active && !over_c && !under_c) ? val_c : 16'sh0000;
            stat_q[s1_ch_q] <= '{valid: active && !over_c && !under_c, over: over_c, under: under_c,
                                 dp: c2.dp, value: (active && !over_c && !under_c) ? val_c : 16'sh0000};
         end
      end
   end

   // ----------------------------------------------------------------
   // alarms: one evaluator per channel and per alarm
   // ----------------------------------------------------------------
   // next alarm state; without hysteresis it is a plain compare
   function automatic logic al_next(input logic cur, input logic above, input logic signed [15:0] v,
                                    input logic signed [15:0] thr, input logic signed [15:0] hys);
      logic signed [17:0] set_lvl;
      logic signed [17:0] clr_lvl;
      set_lvl = above ? 18'(thr) + 18'(hys) : 18'(thr) - 18'(hys); // R7
      clr_lvl = above ? 18'(thr) - 18'(hys) : 18'(thr) + 18'(hys); // R8
      if (hys <= 16'sh0000) begin
         return above ? (v > thr) : (v < thr); // R3 R4
      end else if (above) begin
         return cur ? !(18'(v) < clr_lvl) : (18'(v) > set_lvl); // R7 R8
      end else begin
         return cur ? !(18'(v) > clr_lvl) : (18'(v) < set_lvl); // R7 R8
      end
   endfunction

   for (genvar g = 0; g < NUM_CH; g++) begin : g_alarm
      // both alarms of a channel update on each of its values;
      // out-of-range results leave them as they were
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            alarm1[g] <= 1'b0;
            alarm2[g] <= 1'b0;
         end else if (s1_valid_q && s1_ch_q == 3'(g)) begin // R5
            if (!active) begin
               alarm1[g] <= 1'b0;
               alarm2[g] <= 1'b0;
            end else if (!over_c && !under_c) begin
               alarm1[g] <= al_next(alarm1[g], c2.al1_above, val_c, thr_q[g][0], hys_q[g][0]); // R2
               alarm2[g] <= al_next(alarm2[g], c2.al2_above, val_c, thr_q[g][1], hys_q[g][1]); // R2
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic in_rng; // stage 2 value is numeric
   assign in_rng = s1_valid_q && active && !over_c && !under_c;

   bus_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // bus timing is our own choice
      bus_req && !ack_q |-> avs_waitrequest ##1 (!avs_waitrequest || !bus_req))
      else $error("bus answer not after one wait state");
   res_lat_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
      sample_valid && 32'(sample_ch) < NUM_CH |-> ##2 res_strobe && res_ch == $past(sample_ch, 2))
      else $error("result not two cycles after sample");
   above_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
      in_rng && c2.al1_above && hys_q[s1_ch_q][0] == 16'sh0000
      |=> alarm1[$past(s1_ch_q)] == $past(val_c > thr_q[s1_ch_q][0]))
      else $error("above alarm wrong");
   below_cmp_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
      in_rng && !c2.al2_above && hys_q[s1_ch_q][1] == 16'sh0000
      |=> alarm2[$past(s1_ch_q)] == $past(val_c < thr_q[s1_ch_q][1]))
      else $error("below alarm wrong");
   hys_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
      in_rng && c2.al1_above && hys_q[s1_ch_q][0] > 16'sh0000 && !alarm1[s1_ch_q]
      && 18'(val_c) <= 18'(thr_q[s1_ch_q][0]) + 18'(hys_q[s1_ch_q][0]) |=> !alarm1[$past(s1_ch_q)])
      else $error("alarm set inside hysteresis band");
   hys_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
      in_rng && c2.al1_above && hys_q[s1_ch_q][0] > 16'sh0000 && alarm1[s1_ch_q]
      && 18'(val_c) >= 18'(thr_q[s1_ch_q][0]) - 18'(hys_q[s1_ch_q][0]) |=> alarm1[$past(s1_ch_q)])
      else $error("alarm dropped inside hysteresis band");
   range_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
      res_strobe |-> !(res_data.valid && (res_data.over || res_data.under)) && !(res_data.over && res_data.under))
      else $error("numeric result together with range flag");
   off_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
      s1_valid_q && !active |=> !alarm1[$past(s1_ch_q)] && !alarm2[$past(s1_ch_q)] && !res_data.valid)
      else $error("inactive channel left alarm or value");
   scale_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
      in_rng && s1_x_q == s_min |=> res_data.value == $past(bot_q[s1_ch_q]))
      else $error("span minimum not shown as bottom value");

   over_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) res_strobe && res_data.over);
   alarm_rise_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(alarm1[0]));
   bus_write_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_acc && ch_hit);

endmodule // csau_unit

// ### testbench/csau_adc_model.sv
// Purpose: converter model feeding one sample a call
// Assumes: single ref_clk domain
// Notes: idle data bus shows the inverse of the last value
`timescale 1ns/10ps
module csau_adc_model (
   // clock
   input wire logic ref_clk,
   // sample stream
   output logic sample_valid,
   output logic [2:0] sample_ch,
   output logic [15:0] sample_data
);
   initial begin
      sample_valid = 1'b0;
      sample_ch = 3'h0;
      sample_data = 16'hFFFF;
   end
   // one-cycle pulse, then scramble so stale data never looks valid
   task automatic send(input logic [15:0] d);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_data <= d;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      sample_data <= ~d;
   endtask
endmodule // csau_adc_model

// ### testbench/csau_unit_tb.sv
// Purpose: self-checking bench of the scaling and alarm unit
// Assumes: one wait state per access, result two edges after a sample
// Notes: channel 0 only
`timescale 1ns/10ps
module csau_unit_tb;
   import csau_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic avs_waitrequest, sample_valid, res_strobe, fahrenheit;
   logic [2:0] sample_ch, res_ch;
   logic [15:0] sample_data;
   logic [7:0] alarm1, alarm2;
   csau_res_t res_data;
   int mismatches = 0, compares = 0;
   always #12.5 ref_clk = ~ref_clk;
   csau_adc_model adc (.ref_clk(ref_clk), .sample_valid(sample_valid), .sample_ch(sample_ch), .sample_data(sample_data));
   csau_unit dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid), .sample_ch(sample_ch),
      .sample_data(sample_data), .res_strobe(res_strobe), .res_ch(res_ch), .res_data(res_data),
      .alarm1(alarm1), .alarm2(alarm2), .fahrenheit(fahrenheit));
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // one access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_write <= w;
      avs_read <= ~w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic step(input logic [15:0] x);
      int n;
      adc.send(x);
      for (n = 0; n < 8 && res_strobe !== 1'b1; n++) @(posedge ref_clk);
      chk("latency", n, 2);
      chk("result channel", {res_strobe, res_ch}, 4'h8);
   endtask
   task automatic t_alarm;
      logic [15:0] xs [5] = '{16'h0398, 16'h04B0, 16'h0366, 16'h0348, 16'h01C2};
      logic [1:0] es [5] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1};
      bus(1'b1, 12'h200, 32'h00000304);
      bus(1'b1, 12'h204, 32'h00000640);
      bus(1'b1, 12'h20C, 32'h003201F4);
      bus(1'b1, 12'h210, 32'h00000064);
      for (int i = 0; i < 5; i++) begin
         step(xs[i]);
         chk("value", {res_data.valid, res_data.dp, res_data.value}, {1'b1, 2'h2, xs[i] - 16'h0190});
         chk("alarms", {alarm1[0], alarm2[0]}, es[i]);
      end
      $display("alarm test done");
   endtask
   task automatic t_range;
      step(16'h07D1);
      chk("over", {res_data.valid, res_data.over, res_data.under}, 3'h2);
      step(16'h018F);
      chk("under", {res_data.valid, res_data.over, res_data.under}, 3'h1);
      bus(1'b1, 12'h208, 32'h000A0000);
      step(16'h018F);
      chk("lower ext", {res_data.valid, res_data.value}, {1'b1, 16'hFFFF});
      bus(1'b1, 12'h200, 32'h00000002);
      bus(1'b1, 12'h204, 32'h07D00000);
      step(16'h0064);
      chk("falling", {res_data.valid, res_data.value}, {1'b1, 16'h076C});
      $display("range test done");
   endtask
   task automatic t_regs;
      bus(1'b1, 12'h214, 32'hFFFFFFFF);
      bus(1'b0, 12'h214, 32'h0);
      chk("stat", rd, 32'h0001076C);
      bus(1'b0, 12'h1FC, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, 12'h218, 32'h6C657665);
      bus(1'b0, 12'h218, 32'h0);
      chk("label", rd, 32'h6C657665);
      bus(1'b1, 12'h000, 32'h00000001);
      repeat (2) @(posedge ref_clk);
      chk("fahrenheit", fahrenheit, 1'b1);
      $display("register test done");
   endtask
   // 2-10 V, smoothing level 1, three digits, then a current channel on a voltage-only code
   task automatic t_volt;
      logic [15:0] xs [3] = '{16'h012C, 16'h012C, 16'h00C8};
      logic [15:0] es [3] = '{16'h0000, 16'h0032, 16'h0019};
      bus(1'b1, 12'h200, 32'h00000199);
      bus(1'b1, 12'h204, 32'h00000320);
      for (int i = 0; i < 3; i++) begin
         step(xs[i]);
         chk("smoothed", {res_data.valid, res_data.dp, res_data.value}, {1'b1, 2'h3, es[i]});
         chk("alarms lit", {alarm1[0], alarm2[0]}, 2'h3);
      end
      bus(1'b1, 12'h200, 32'h00000006);
      step(16'h012C);
      chk("inactive", {res_data.valid, res_data.over, res_data.under, alarm1[0], alarm2[0]}, 5'h00);
      $display("voltage test done");
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_alarm();
      t_range();
      t_regs();
      t_volt();
      stop_test();
   end
   initial begin
      #500000;
      mismatches++;
      stop_test();
   end
endmodule // csau_unit_tb
